// file: rtl/rpd_rank_pm.sv
/*
 * Per-rank clock-enable power manager for a DDR3 memory controller.
 * Assumes requests, refresh and package state inputs are synchronous to
 * ref_clk_i, and that a command scheduler obeys rank_ready_o.
 */
`timescale 1ns/1ps

`include "rpd_regs.svh"

module rpd_rank_pm
    import rpd_pkg::*;
#(
    parameter int RANKS = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [RANKS-1:0] req_i,
    input wire logic [RANKS-1:0] pages_open_i,
    input wire logic pending_i,
    input wire logic pkg_c3_i,
    input wire logic refresh_req_i,
    input wire logic refresh_done_i,
    input wire logic [RANKS-1:0] throttle_i,
    output logic [RANKS-1:0] precharge_all_o,
    output logic [RANKS-1:0] rank_ready_o,
    output logic [RANKS-1:0] data_ready_o,
    output logic [RANKS-1:0] sref_o,
    output logic [RANKS-1:0] dll_off_o,
    output logic [RANKS-1:0] rx_en_o,
    output rpd_pins_t [RANKS-1:0] pins_o
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    logic [15:0] pdcfg;
    logic cke_en;
    logic lock;
    logic tri_en;
    logic dyn_en;
    logic [3:0] populated;
    logic [3:0] gfx_rank;
    logic [7:0] txp;
    logic [7:0] txpdll;
    rpd_state_t state [RANKS];
    logic [RANKS-1:0] in_sref;
    logic [RANKS-1:0] in_pd;
    logic wr_acc;
    logic rd_acc;
    logic bad_addr;

    // Byte address decode; unmapped addresses answer with pslverr.
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `RPD_PDCFG_OFF) || (a == `RPD_CTRL_OFF) ||
            (a == `RPD_STATUS_OFF) || (a == `RPD_TIMING_OFF);
    endfunction

    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign rd_acc = psel_i && penable_i && !pwrite_i;
    assign bad_addr = !mapped(paddr_i);

    // Every access completes in its first access cycle, so pready is a
    // flop raised in the setup cycle and dropped once the access ends.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped(paddr_i);
        end
    end

    // Config register stays writable at run time until the lock is set.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pdcfg <= `RPD_PDCFG_RST;
        end else if (wr_acc && pready_o && paddr_i == `RPD_PDCFG_OFF && !lock) begin
            pdcfg <= pwdata_i[15:0];
        end
    end

    // Control: CKE enable, lock, tri-state enable, populated and graphics masks.
    // Populated resets to all ones so no present module loses its data.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cke_en <= 1'b0;
            lock <= 1'b0;
            tri_en <= 1'b0;
            dyn_en <= 1'b0;
            populated <= 4'hf;
            gfx_rank <= 4'h0;
        end else if (wr_acc && pready_o && paddr_i == `RPD_CTRL_OFF && !lock) begin
            cke_en <= pwdata_i[`RPD_CTRL_CKE_EN];
            lock <= pwdata_i[`RPD_CTRL_LOCK];
            tri_en <= pwdata_i[`RPD_CTRL_TRI_EN];
            populated <= pwdata_i[`RPD_CTRL_POP_LO +: 4];
            gfx_rank <= pwdata_i[`RPD_CTRL_GFX_LO +: 4];
            dyn_en <= pwdata_i[`RPD_CTRL_DYN];
        end
    end

    // Exit timing counts, adjustable because tXPDLL differs by DDR type.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            txp <= `RPD_TXP_CYC;
            txpdll <= `RPD_TXPDLL_CYC;
        end else if (wr_acc && pready_o && paddr_i == `RPD_TIMING_OFF && !lock) begin
            txp <= pwdata_i[7:0];
            txpdll <= pwdata_i[15:8];
        end
    end

    // Read data is registered in the setup cycle; status shows rank states.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            case (paddr_i)
                `RPD_PDCFG_OFF: prdata_o <= {16'h0000, pdcfg};
                `RPD_CTRL_OFF: prdata_o <= {15'h0000, dyn_en, gfx_rank, populated,
                    5'h00, tri_en, lock, cke_en};
                `RPD_STATUS_OFF: prdata_o <= {24'h000000, 4'(in_sref), 4'(in_pd)};
                `RPD_TIMING_OFF: prdata_o <= {16'h0000, txpdll, txp};
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ****************************************************************
    // Per-rank power-down engine
    // ****************************************************************
    logic [3:0] pd_type;
    logic [11:0] expiry;
    logic sref_req;
    logic refresh_hold;

    assign pd_type = pdcfg[`RPD_TYPE_HI:`RPD_TYPE_LO];
    assign expiry = pdcfg[`RPD_IDLE_HI:`RPD_IDLE_LO];
    // Self-refresh only once pending cycles have drained.
    assign sref_req = pkg_c3_i && !pending_i;

    // Refresh window: held from request to completion under dynamic power-down.
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            refresh_hold <= 1'b0;
        end else if (refresh_req_i && dyn_en) begin
            refresh_hold <= 1'b1;
        end else if (refresh_done_i) begin
            refresh_hold <= 1'b0;
        end
    end

    for (genvar r = 0; r < RANKS; r++) begin : g_rank
        logic [11:0] idle_cnt;
        logic [7:0] exit_cnt;
        logic [7:0] data_cnt;
        logic pop;
        logic drive;
        logic wake;

        assign pop = populated[r] || !tri_en;
        assign drive = pop;
        // Refresh and requests, or an asserted throttle, pull the rank out.
        assign wake = req_i[r] || refresh_hold || throttle_i[r] || !cke_en;

        // Idle counter reloads on every arrival and stops at expiry. Entry compares with >=
        // so that a lowered expiry takes effect at once instead of leaving the rank awake until the next arrival reloads the counter.
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                idle_cnt <= 12'h000;
            end else if (req_i[r] || state[r] != RPD_ACTIVE) begin
                idle_cnt <= 12'h000;
            end else if (idle_cnt < expiry) begin
                idle_cnt <= idle_cnt + 12'h001;
            end
        end

        // Rank state machine.
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                state[r] <= RPD_ACTIVE;
                exit_cnt <= 8'h00;
                data_cnt <= 8'h00;
                dll_off_o[r] <= 1'b0;
            end else begin
                case (state[r])
                    RPD_ACTIVE: begin
                        if (cke_en && sref_req && !gfx_rank[r]) begin
                            state[r] <= RPD_SREF;
                        end else if (cke_en && !wake && pd_type != `RPD_TYPE_NONE &&
                                idle_cnt >= expiry) begin
                            if (pd_type == `RPD_TYPE_PPD && pages_open_i[r]) begin
                                state[r] <= RPD_PRECH;
                            end else begin
                                state[r] <= RPD_PDOWN;
                                dll_off_o[r] <= pd_type == `RPD_TYPE_PPD;
                            end
                        end
                    end
                    RPD_PRECH: begin
                        if (wake) begin
                            state[r] <= RPD_ACTIVE;
                        end else if (!pages_open_i[r]) begin
                            state[r] <= RPD_PDOWN;
                            dll_off_o[r] <= 1'b1;
                        end
                    end
                    RPD_PDOWN: begin
                        if (wake || (sref_req && !gfx_rank[r])) begin
                            state[r] <= RPD_EXIT;
                            exit_cnt <= txp;
                            data_cnt <= dll_off_o[r] ? txpdll : txp;
                        end
                    end
                    RPD_EXIT: begin
                        if (exit_cnt != 8'h00) begin
                            exit_cnt <= exit_cnt - 8'h01;
                        end
                        if (data_cnt != 8'h00) begin
                            data_cnt <= data_cnt - 8'h01;
                        end else begin
                            state[r] <= RPD_ACTIVE;
                            dll_off_o[r] <= 1'b0;
                        end
                    end
                    RPD_SREF: begin
                        if (!sref_req) begin
                            state[r] <= RPD_EXIT;
                            exit_cnt <= txpdll;
                            data_cnt <= txpdll;
                        end
                    end
                    default: state[r] <= RPD_ACTIVE;
                endcase
            end
        end

        // Output pins and status flops; every output leaves a flop.
        always_ff @(posedge ref_clk_i or posedge rst_i) begin
            if (rst_i) begin
                pins_o[r] <= '{cke: 1'b0, cke_oe: 1'b1, cs_oe: 1'b1, odt_oe: 1'b1,
                    clk_oe: 1'b1};
                rank_ready_o[r] <= 1'b0;
                data_ready_o[r] <= 1'b0;
                precharge_all_o[r] <= 1'b0;
                sref_o[r] <= 1'b0;
                rx_en_o[r] <= 1'b1;
                in_pd[r] <= 1'b0;
                in_sref[r] <= 1'b0;
            end else begin
                pins_o[r].cke <= cke_en && drive &&
                    (state[r] == RPD_ACTIVE || state[r] == RPD_PRECH ||
                    state[r] == RPD_EXIT);
                pins_o[r].cke_oe <= drive;
                pins_o[r].cs_oe <= drive;
                pins_o[r].odt_oe <= drive;
                pins_o[r].clk_oe <= drive;
                rx_en_o[r] <= drive;
                rank_ready_o[r] <= cke_en && drive && (state[r] == RPD_ACTIVE ||
                    (state[r] == RPD_EXIT && exit_cnt == 8'h00));
                data_ready_o[r] <= cke_en && drive && state[r] == RPD_ACTIVE;
                precharge_all_o[r] <= state[r] == RPD_PRECH;
                sref_o[r] <= state[r] == RPD_SREF;
                in_pd[r] <= state[r] == RPD_PDOWN;
                in_sref[r] <= state[r] == RPD_SREF;
            end
        end

        // ************************************************************
        // Checks
        // ************************************************************
        // Wake from power-down, and entry decided while precharge power-down is selected.
        sequence pd_to_exit_s;
            state[r] == RPD_PDOWN ##1 state[r] == RPD_EXIT;
        endsequence
        sequence ppd_entry_s;
            (state[r] == RPD_ACTIVE && pd_type == `RPD_TYPE_PPD) ##1 state[r] == RPD_PDOWN;
        endsequence

        cke_reset_low_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i) !cke_en |=> !pins_o[r].cke)
            else $error("CKE high before software enable");
        unpop_undriven_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            (tri_en && !populated[r]) |=> (!pins_o[r].cke_oe && !pins_o[r].cs_oe))
            else $error("Unpopulated rank still driven");
        default_pop_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i) !tri_en |=> pins_o[r].cke_oe)
            else $error("Rank undriven before tri-state enable");
        no_pd_mode_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            (state[r] == RPD_ACTIVE && pd_type == `RPD_TYPE_NONE && !sref_req)
            |=> state[r] == RPD_ACTIVE)
            else $error("Power-down with power-down disabled");
        idle_early_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            (state[r] == RPD_ACTIVE && idle_cnt < expiry && !sref_req)
            |=> state[r] == RPD_ACTIVE)
            else $error("Rank left active before idle expiry");
        ppd_close_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            ppd_entry_s |-> !$past(pages_open_i[r]))
            else $error("Precharge power-down with pages open");
        wake_exit_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            (state[r] == RPD_PDOWN && req_i[r]) |=> state[r] == RPD_EXIT)
            else $error("Request did not wake the rank");
        // Five ready-low cycles match the reset tXP count; shorter programmed values skip it.
        exit_wait_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            ((txp >= `RPD_TXP_CYC) throughout pd_to_exit_s) |-> ##1 (!rank_ready_o[r] [*5]))
            else $error("Command allowed before tXP");
        refresh_wake_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i)
            (refresh_hold && state[r] == RPD_ACTIVE && !sref_req)
            |=> state[r] == RPD_ACTIVE)
            else $error("Rank powered down during refresh");
        lock_hold_a: assert property (
            @(posedge ref_clk_i) disable iff (rst_i) lock |=> $stable(pdcfg))
            else $error("Config changed while locked");
    end

endmodule // rpd_rank_pm

// file: rtl/rpd_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * DRAM rank power-down block.
 * Assumes a 32-bit APB slave with byte addresses and one word per register.
 */
`ifndef RPD_REGS_SVH
`define RPD_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define RPD_PDCFG_OFF 12'h000
`define RPD_CTRL_OFF 12'h004
`define RPD_STATUS_OFF 12'h008
`define RPD_TIMING_OFF 12'h00c

// ****************************************************************
// Field positions
// ****************************************************************
`define RPD_TYPE_HI 15
`define RPD_TYPE_LO 12
`define RPD_IDLE_HI 11
`define RPD_IDLE_LO 0
`define RPD_CTRL_CKE_EN 0
`define RPD_CTRL_LOCK 1
`define RPD_CTRL_TRI_EN 2
`define RPD_CTRL_POP_LO 8
`define RPD_CTRL_GFX_LO 12
`define RPD_CTRL_DYN 16

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RPD_PDCFG_RST 16'h0000
`define RPD_TYPE_NONE 4'h0
`define RPD_TYPE_APD 4'h1
`define RPD_TYPE_PPD 4'h6

// ****************************************************************
// Exit timing in dram clock cycles
// ****************************************************************
`define RPD_TXP_CYC 8'h05
`define RPD_TXPDLL_CYC 8'h14

`endif

// file: rtl/rpd_pkg.sv
/*
 * Types shared by the DRAM rank power-down block.
 * Assumes rpd_regs.svh supplies the numeric constants.
 */
package rpd_pkg;

    // Per-rank state, Gray coded along idle, precharge, power-down, exit, self-refresh.
    typedef enum logic [2:0] {
        RPD_ACTIVE = 3'h0,
        RPD_PRECH = 3'h1,
        RPD_PDOWN = 3'h3,
        RPD_EXIT = 3'h2,
        RPD_SREF = 3'h6
    } rpd_state_t;

    // Pin group of one rank: CKE level and output enables for CKE, CS, ODT and clock.
    typedef struct packed {
        logic cke;
        logic cke_oe;
        logic cs_oe;
        logic odt_oe;
        logic clk_oe;
    } rpd_pins_t;

endpackage

// file: dv/rpd_dram_model.sv
/*
 * Behavioural model of the DRAM ranks behind the rank power manager.
 * Assumes it sees the pin group and the ready flags on ref_clk_i.
 */
`timescale 1ns/1ps

`include "rpd_regs.svh"

module rpd_dram_model
    import rpd_pkg::*;
#(
    parameter int RANKS = 4
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic [RANKS-1:0] req_i,
    input wire logic [RANKS-1:0] precharge_all_i,
    input wire logic [RANKS-1:0] rank_ready_i,
    input wire logic [RANKS-1:0] data_ready_i,
    input wire logic [RANKS-1:0] dll_off_i,
    input wire rpd_pins_t [RANKS-1:0] pins_i,
    output logic [RANKS-1:0] pages_open_o,
    output int viol_o
);
    // ****************************************************************
    // Page state and exit timing watch
    // ****************************************************************
    int up_cnt [RANKS];
    logic [RANKS-1:0] armed, slow, last_cke, last_rdy, last_dat;

    // Counters use blocking updates; only the page flags feed the design.
    always @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pages_open_o <= '0;
            viol_o = 0;
            armed = '0;
            slow = '0;
            last_cke = '0;
            last_rdy = '0;
            last_dat = '0;
            foreach (up_cnt[r]) up_cnt[r] = 0;
        end else begin
            for (int r = 0; r < RANKS; r++) begin
                // A page opens only when a request is served by a ready rank.
                if (precharge_all_i[r]) pages_open_o[r] <= 1'b0;
                else if (req_i[r] && rank_ready_i[r]) pages_open_o[r] <= 1'b1;
                if (last_cke[r] && !pins_i[r].cke) begin
                    armed[r] = 1'b1;
                    slow[r] = dll_off_i[r];
                    // A DLL-off entry must find every page already closed.
                    if (dll_off_i[r] && pages_open_o[r]) viol_o++;
                end else if (!pins_i[r].cke) slow[r] = slow[r] | dll_off_i[r];
                // Ready earlier than the exit time would hit a sleeping rank.
                if (armed[r] && rank_ready_i[r] && !last_rdy[r] && up_cnt[r] < `RPD_TXP_CYC)
                    viol_o++;
                if (armed[r] && data_ready_i[r] && !last_dat[r]
                    && up_cnt[r] < (slow[r] ? `RPD_TXPDLL_CYC : `RPD_TXP_CYC))
                    viol_o++;
                up_cnt[r] = pins_i[r].cke ? up_cnt[r] + 1 : 0;
                last_cke[r] = pins_i[r].cke;
                last_rdy[r] = rank_ready_i[r];
                last_dat[r] = data_ready_i[r];
            end
        end
    end
endmodule // rpd_dram_model

// file: dv/testbench.sv
/*
 * Self-checking bench for the rank power manager with a register model.
 * Assumes the design answers APB and the rank model answers page state.
 */
`timescale 1ns/1ps

`include "rpd_regs.svh"

module testbench
    import rpd_pkg::*;
;
    // ****************************************************************
    // Signals, instances and helpers
    // ****************************************************************
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = '0;
    logic [31:0] pwdata_i = '0;
    logic [31:0] prdata_o, q;
    logic pready_o, pslverr_o, pending_i = 1'b0, pkg_c3_i = 1'b0;
    logic refresh_req_i = 1'b0, refresh_done_i = 1'b0, locked = 1'b0;
    logic [3:0] req_i = '0, throttle_i = '0, pages_open_i;
    logic [3:0] precharge_all_o, rank_ready_o, data_ready_o, sref_o, dll_off_o, rx_en_o;
    rpd_pins_t [3:0] pins_o;
    logic [31:0] mdl [4];
    logic [3:0] types [3] = '{`RPD_TYPE_NONE, `RPD_TYPE_APD, `RPD_TYPE_PPD};
    int error_cnt = 0, check_count = 0, cyc_cnt = 0, viol, idle, n;

    always #2 ref_clk_i = ~ref_clk_i;

    rpd_rank_pm #(.RANKS(4)) rpd_rank_pm_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .req_i(req_i), .pages_open_i(pages_open_i), .pending_i(pending_i),
        .pkg_c3_i(pkg_c3_i), .refresh_req_i(refresh_req_i), .refresh_done_i(refresh_done_i),
        .throttle_i(throttle_i), .precharge_all_o(precharge_all_o),
        .rank_ready_o(rank_ready_o), .data_ready_o(data_ready_o), .sref_o(sref_o),
        .dll_off_o(dll_off_o), .rx_en_o(rx_en_o), .pins_o(pins_o));

    rpd_dram_model #(.RANKS(4)) rpd_dram_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .req_i(req_i), .precharge_all_i(precharge_all_o), .rank_ready_i(rank_ready_o),
        .data_ready_i(data_ready_o), .dll_off_i(dll_off_o), .pins_i(pins_o),
        .pages_open_o(pages_open_i), .viol_o(viol));

    function automatic logic [3:0] ckev();
        for (int r = 0; r < 4; r++) ckev[r] = pins_o[r].cke;
    endfunction

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic ok, input string m);
        check_count++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask

    // One APB transfer; entered just after a rising edge, leaves one idle cycle.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        // Only the bench timeout ends a wait for pready.
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        r = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    // The model ignores status writes, unmapped places and anything after lock.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic e;
        logic [31:0] r;
        apb(1'b1, a, d, r, e);
        chk(e === (a > 12'h00c), "write response");
        if (a < 12'h010 && a != 12'h008 && !locked)
            mdl[a[3:2]] = d & ((a == 12'h004) ? 32'h0001_ff07 : 32'h0000_ffff);
        if (a == 12'h004 && !locked) locked = d[1];
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(e === (a > 12'h00c), "read response");
        if (a < 12'h010 && a != 12'h008) chk(r === mdl[a[3:2]], "read data");
    endtask

    task automatic waitcke(input logic [3:0] v, input string m);
        n = 0;
        while (ckev() !== v && n < 64) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(ckev() === v, m);
    endtask

    // A hang is cut short here and still reaches the closing report.
    always @(posedge ref_clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        void'($urandom(29952));
        mdl = '{32'h0, 32'h0000_0f00, 32'h0, 32'h0000_1405};
        repeat (16) @(posedge ref_clk_i);
        chk(ckev() === 4'h0 && pins_o[0].cke_oe === 1'b1 && pins_o[3].cs_oe === 1'b1, "rst");
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        for (int a = 0; a < 5; a++) rd(12'(a * 4), q);
        wr(`RPD_CTRL_OFF, 32'h0001_0f01);
        waitcke(4'hf, "cke enable");
        foreach (types[t]) begin
            idle = 16 + int'($urandom % 32);
            wr(`RPD_PDCFG_OFF, {16'h0, types[t], 12'(idle)});
            rd(`RPD_PDCFG_OFF, q);
            req_i <= 4'h1;
            // Rank one keeps getting work, rank zero is left idle; ranks two and three
            // have idled since earlier, so only the first two are checked early.
            for (int k = 0; k < idle + 24; k++) begin
                @(posedge ref_clk_i);
                req_i <= (k % 8 == 7) ? 4'h2 : 4'h0;
                if (k == idle - 4) chk((ckev() & 4'h3) === 4'h3, "early entry");
            end
            chk(ckev() === ((types[t] == `RPD_TYPE_NONE) ? 4'hf : 4'h2), "idle");
            rd(`RPD_STATUS_OFF, q);
            chk(q[3:0] === ((types[t] == `RPD_TYPE_NONE) ? 4'h0 : 4'hd), "status");
            if (types[t] != `RPD_TYPE_NONE) begin
                chk(pages_open_i[0] === (types[t] == `RPD_TYPE_APD), "pages");
                chk(dll_off_o[0] === (types[t] == `RPD_TYPE_PPD), "dll");
            end
            req_i <= 4'h1;
            @(posedge ref_clk_i);
            req_i <= 4'h0;
            n = 0;
            while (data_ready_o[0] !== 1'b1 && n < 64) begin
                @(posedge ref_clk_i);
                n++;
            end
            chk(rank_ready_o[0] === 1'b1 && data_ready_o[0] === 1'b1, "wake");
        end
        refresh_req_i <= 1'b1;
        @(posedge ref_clk_i);
        refresh_req_i <= 1'b0;
        waitcke(4'hf, "refresh wake");
        refresh_done_i <= 1'b1;
        @(posedge ref_clk_i);
        refresh_done_i <= 1'b0;
        waitcke(4'h0, "refresh sleep");
        throttle_i <= 4'h1;
        req_i <= 4'h1;
        @(posedge ref_clk_i);
        req_i <= 4'h0;
        repeat (idle + 24) @(posedge ref_clk_i);
        chk(ckev() === 4'h1, "throttle");
        throttle_i <= 4'h0;
        wr(`RPD_CTRL_OFF, 32'h0001_8f01);
        pending_i <= 1'b1;
        pkg_c3_i <= 1'b1;
        repeat (32) @(posedge ref_clk_i);
        chk(sref_o === 4'h0, "sref pending");
        pending_i <= 1'b0;
        n = 0;
        while (sref_o !== 4'h7 && n < 64) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(sref_o === 4'h7 && (ckev() & 4'h7) === 4'h0, "sref");
        pkg_c3_i <= 1'b0;
        n = 0;
        while (sref_o !== 4'h0 && n < 64) begin
            @(posedge ref_clk_i);
            n++;
        end
        chk(sref_o === 4'h0, "sref exit");
        wr(`RPD_CTRL_OFF, 32'h0000_0305);
        repeat (4) @(posedge ref_clk_i);
        chk({pins_o[3].cke_oe, pins_o[3].cs_oe, pins_o[3].odt_oe, pins_o[3].clk_oe,
             rx_en_o[3]} === 5'h0, "unused rank");
        chk(pins_o[0].cke_oe === 1'b1 && pins_o[0].cs_oe === 1'b1, "used rank");
        wr(`RPD_PDCFG_OFF, 32'h0000_6080);
        wr(`RPD_CTRL_OFF, 32'h0000_0307);
        wr(`RPD_PDCFG_OFF, 32'h0000_1234);
        rd(`RPD_PDCFG_OFF, q);
        wr(12'h01c, 32'h1);
        chk(viol == 0, "exit timing");
        summarize();
    end
endmodule // testbench
